// *** common/power_switch_monitor_pkg.sv ***
package power_switch_monitor_pkg;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  // Register pointer values (three-bit pointer)
  localparam logic [2:0] ADDR_ALERT_MASK = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_FAULT = 3'h3;
  localparam logic [2:0] ADDR_SHUNT = 3'h4;
  localparam logic [2:0] ADDR_RAIL = 3'h5;
  localparam logic [2:0] ADDR_AUX = 3'h6;

  // Status bit positions
  localparam int ST_PASS_ON = 7;
  localparam int ST_PIN_ONE = 6;
  localparam int ST_PIN_TWO = 5;
  localparam int ST_CARD_IN = 4;
  localparam int ST_POWER_BAD = 3;
  localparam int ST_PIN_THREE = 2;
  localparam int ST_UNDER = 1;
  localparam int ST_OVER = 0;

  // Fault bit positions; alert-enable bits share positions 3:0
  localparam int FLT_PIN_THREE = 7;
  localparam int FLT_PIN_TWO = 6;
  localparam int FLT_SHORT = 5;
  localparam int FLT_CARD = 4;
  localparam int FLT_POWER_BAD = 3;
  localparam int FLT_OVERCURRENT = 2;
  localparam int FLT_UNDER = 1;
  localparam int FLT_OVER = 0;

  // Reset values
  localparam logic [7:0] FAULT_RST = 8'h80;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;

  // Shunt result scaling and short threshold
  localparam int SENSE_LSB_UV = 151;
  localparam int SHORT_LIMIT_UV = 1000;
  localparam logic [7:0] SHORT_CODE_MAX = 8'(SHORT_LIMIT_UV / SENSE_LSB_UV);

  typedef enum logic [1:0] {
    CH_SHUNT = 2'b00,
    CH_RAIL = 2'b01,
    CH_AUX = 2'b10
  } adc_channel_t;

  typedef struct packed {
    logic valid;
    adc_channel_t channel;
    logic [7:0] data;
  } adc_sample_t;

  typedef struct packed {
    logic pass_transistor_on;
    logic general_pin_one;
    logic general_pin_two;
    logic general_pin_three;
    logic card_detect_n;
    logic power_good_feedback;
    logic undervoltage_input;
    logic supply_high_input;
    logic vdd_high;
  } pin_in_t;

endpackage

// *** rtl/level_sync2.sv ***
`timescale 1ns/1ns
module level_sync2
  import power_switch_monitor_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // First stage feeds only the second stage
  always_comb begin
    st_next.first = d_i;
    st_next.second = st_reg.first;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.second;

endmodule // level_sync2

// *** rtl/fault_bit_latch.sv ***
`timescale 1ns/1ns
module fault_bit_latch
  import power_switch_monitor_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Hardware set and host write
  input wire logic [WIDTH-1:0] set_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Latched value and its next value
  output logic [WIDTH-1:0] q_o,
  output logic [WIDTH-1:0] q_next_o
);

  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } latch_state_t;

  latch_state_t st_reg;
  latch_state_t st_next;
  logic [WIDTH-1:0] bit_next;

  // A set in the cycle of a clearing write keeps the bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign bit_next[i] = set_i[i] | (wr_i ? wdata_i[i] : st_reg.bits[i]);
  end

  always_comb begin
    st_next.bits = bit_next;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.bits <= RESET_VALUE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.bits;
  assign q_next_o = bit_next;

endmodule // fault_bit_latch

// *** rtl/power_switch_monitor_regs.sv ***
`timescale 1ns/1ns
// Behaviour
// - alert-enable bit 3 gates power-bad alerts
// - alert-enable bit 2 gates overcurrent alerts
// - alert-enable bit 1 gates undervoltage alerts
// - alert-enable bit 0 gates overvoltage alerts
// - status bit 7 shows pass transistor on
// - status bits 6,5,2 show general pins
// - status bit 4 set while card-detect low
// - status bit 3 set while feedback low
// - status bit 1 set while undervoltage low
// - status bit 0 set on any overvoltage
// - fault bit 7 pulls pin three, reset 1
// - fault bit 6 pulls pin two, reset 0
// - fault bit 5 latches possible transistor short
// - fault bit 4 latches card-detect change
// - fault bit 3 latches power-bad event
// - fault bit 2 latches overcurrent event
// - fault bit 1 latches undervoltage event
// - fault bit 0 latches overvoltage event
// - shunt result holds 8-bit sense conversion
// - rail result holds 8-bit output conversion
// - aux result holds 8-bit auxiliary conversion
// - enabled latched fault pulls pin two low
// - alert response or addressing releases pin two
// - no new alert while fault bit stays
module power_switch_monitor_regs
  import power_switch_monitor_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin levels and comparator outputs
  input wire pin_in_t pins_i,
  // Monitor events on this clock
  input wire logic overcurrent_i,
  input wire adc_sample_t adc_i,
  // Register port from the bus engine
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Alert response from the bus engine
  input wire logic ara_sent_i,
  input wire logic addressed_i,
  // Open-drain general pins and alert pending flag
  output logic general_pin_two_o,
  output logic general_pin_two_oe_n_o,
  output logic general_pin_three_o,
  output logic general_pin_three_oe_n_o,
  output logic alert_pending_o
);

  typedef struct packed {
    logic [3:0] alert_enable_mask;
    logic [7:0] shunt_drop_result;
    logic [7:0] output_rail_result;
    logic [7:0] aux_analog_result;
    logic card_detect_n_last;
    logic [2:0] warm;
    logic alert;
    logic pin_two_drive;
    logic pin_three_drive;
    logic [7:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    alert_enable_mask: MASK_RST,
    shunt_drop_result: RESULT_RST,
    output_rail_result: RESULT_RST,
    aux_analog_result: RESULT_RST,
    card_detect_n_last: 1'b1,
    warm: 3'b000,
    alert: 1'b0,
    pin_two_drive: FAULT_RST[FLT_PIN_TWO],
    pin_three_drive: FAULT_RST[FLT_PIN_THREE],
    rdata: 8'h00
  };

  state_t st_reg;
  state_t st_next;
  pin_in_t pin_sync;
  logic [$bits(pin_in_t)-1:0] pin_sync_bits;
  logic [7:0] status_w;
  logic [7:0] fault_set;
  logic [7:0] fault_q;
  logic [7:0] fault_next;
  logic [7:0] fault_rise;
  logic fault_wr;
  logic alert_req;
  logic alert_release;
  logic card_changed;
  logic pins_valid;

  // Pin levels cross into the clock domain
  level_sync2 #(
    .WIDTH($bits(pin_in_t))
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_i),
    .q_o(pin_sync_bits)
  );

  assign pin_sync = pin_in_t'(pin_sync_bits);

  // Live status byte
  assign status_w[ST_PASS_ON] = pin_sync.pass_transistor_on;
  assign status_w[ST_PIN_ONE] = pin_sync.general_pin_one;
  assign status_w[ST_PIN_TWO] = pin_sync.general_pin_two;
  assign status_w[ST_CARD_IN] = ~pin_sync.card_detect_n;
  assign status_w[ST_POWER_BAD] = ~pin_sync.power_good_feedback;
  assign status_w[ST_PIN_THREE] = pin_sync.general_pin_three;
  assign status_w[ST_UNDER] = ~pin_sync.undervoltage_input;
  assign status_w[ST_OVER] = pin_sync.supply_high_input
                             | pin_sync.vdd_high;

  // Synchroniser reset levels are not pin levels: hold off pin faults
  assign pins_valid = st_reg.warm[1];
  assign card_changed = st_reg.warm[2]
                        & (st_reg.card_detect_n_last
                           ^ pin_sync.card_detect_n);

  // Hardware fault events; output bits are never set by hardware
  assign fault_set[FLT_PIN_THREE] = 1'b0;
  assign fault_set[FLT_PIN_TWO] = 1'b0;
  assign fault_set[FLT_SHORT] = pins_valid & ~pin_sync.pass_transistor_on
    & (st_reg.shunt_drop_result > SHORT_CODE_MAX);
  assign fault_set[FLT_CARD] = card_changed;
  assign fault_set[FLT_POWER_BAD] = pins_valid
    & status_w[ST_POWER_BAD];
  assign fault_set[FLT_OVERCURRENT] = overcurrent_i;
  assign fault_set[FLT_UNDER] = pins_valid & status_w[ST_UNDER];
  assign fault_set[FLT_OVER] = pins_valid & status_w[ST_OVER];

  assign fault_wr = reg_wr_i && (reg_addr_i == ADDR_FAULT);

  fault_bit_latch #(
    .WIDTH(8),
    .RESET_VALUE(FAULT_RST)
  ) u_fault (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(fault_set),
    .wr_i(fault_wr),
    .wdata_i(reg_wdata_i),
    .q_o(fault_q),
    .q_next_o(fault_next)
  );

  // Only a bit going from clear to set raises a new alert
  assign fault_rise = fault_next & ~fault_q;
  assign alert_req = |(fault_rise[3:0] & st_reg.alert_enable_mask);
  assign alert_release = ara_sent_i | addressed_i;

  always_comb begin
    st_next = st_reg;
    st_next.card_detect_n_last = pin_sync.card_detect_n;
    st_next.warm = {st_reg.warm[1:0], 1'b1};
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_ALERT_MASK: begin
          st_next.alert_enable_mask = reg_wdata_i[3:0];
        end
        ADDR_SHUNT: begin
          st_next.shunt_drop_result = reg_wdata_i;
        end
        ADDR_RAIL: begin
          st_next.output_rail_result = reg_wdata_i;
        end
        ADDR_AUX: begin
          st_next.aux_analog_result = reg_wdata_i;
        end
        default: begin
          st_next.warm = {st_reg.warm[1:0], 1'b1};
        end
      endcase
    end
    // A finished conversion wins over a host write, whole byte at once
    if (adc_i.valid) begin
      case (adc_i.channel)
        CH_SHUNT: begin
          st_next.shunt_drop_result = adc_i.data;
        end
        CH_RAIL: begin
          st_next.output_rail_result = adc_i.data;
        end
        CH_AUX: begin
          st_next.aux_analog_result = adc_i.data;
        end
        default: begin
          st_next.warm = {st_reg.warm[1:0], 1'b1};
        end
      endcase
    end
    // A new alert in the release cycle keeps the pin low
    if (alert_req) begin
      st_next.alert = 1'b1;
    end else if (alert_release) begin
      st_next.alert = 1'b0;
    end
    st_next.pin_two_drive = fault_next[FLT_PIN_TWO]
                            | st_next.alert;
    st_next.pin_three_drive = fault_next[FLT_PIN_THREE];
    case (reg_addr_i)
      ADDR_ALERT_MASK: st_next.rdata = {4'h0, st_reg.alert_enable_mask};
      ADDR_STATUS: st_next.rdata = status_w;
      ADDR_FAULT: st_next.rdata = fault_q;
      ADDR_SHUNT: st_next.rdata = st_reg.shunt_drop_result;
      ADDR_RAIL: st_next.rdata = st_reg.output_rail_result;
      ADDR_AUX: st_next.rdata = st_reg.aux_analog_result;
      default: st_next.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign general_pin_two_o = 1'b0;
  assign general_pin_two_oe_n_o = ~st_reg.pin_two_drive;
  assign general_pin_three_o = 1'b0;
  assign general_pin_three_oe_n_o = ~st_reg.pin_three_drive;
  assign alert_pending_o = st_reg.alert;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  for (genvar i = 0; i < 4; i++) begin : g_mask_chk
    a_mask_gate_on: assert property (
      fault_rise[i] && st_reg.alert_enable_mask[i]
      |=> st_reg.alert && !general_pin_two_oe_n_o)
      else $error("enabled fault did not raise alert");
  end

  a_alert_cause: assert property (
    $rose(st_reg.alert)
    |-> $past(|(fault_rise[3:0] & st_reg.alert_enable_mask)))
    else $error("alert rose without an enabled new fault");

  a_status_pass_on: assert property (
    reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[ST_PASS_ON] == $past(pin_sync.pass_transistor_on))
    else $error("status pass transistor bit wrong");

  a_status_pins: assert property (
    reg_addr_i == ADDR_STATUS
    |=> {reg_rdata_o[ST_PIN_ONE], reg_rdata_o[ST_PIN_TWO],
         reg_rdata_o[ST_PIN_THREE]}
        == $past({pin_sync.general_pin_one, pin_sync.general_pin_two,
                  pin_sync.general_pin_three}))
    else $error("status general pin bits wrong");

  a_status_card: assert property (
    reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[ST_CARD_IN] == !$past(pin_sync.card_detect_n))
    else $error("status card bit wrong");

  a_status_power_bad: assert property (
    reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[ST_POWER_BAD]
        == !$past(pin_sync.power_good_feedback))
    else $error("status power bad bit wrong");

  a_status_under: assert property (
    reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[ST_UNDER] == !$past(pin_sync.undervoltage_input))
    else $error("status undervoltage bit wrong");

  a_status_over: assert property (
    reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[ST_OVER]
        == $past(pin_sync.supply_high_input | pin_sync.vdd_high))
    else $error("status overvoltage bit wrong");

  a_pin_three_drive: assert property (
    general_pin_three_oe_n_o == !fault_q[FLT_PIN_THREE])
    else $error("pin three enable does not follow fault bit 7");

  a_pin_two_idle: assert property (
    !fault_q[FLT_PIN_TWO] && !st_reg.alert |-> general_pin_two_oe_n_o)
    else $error("pin two driven without cause");

  a_short_latch: assert property (
    pins_valid && !pin_sync.pass_transistor_on
    && st_reg.shunt_drop_result > SHORT_CODE_MAX
    |=> fault_q[FLT_SHORT])
    else $error("transistor short not latched");

  a_card_latch: assert property (
    card_changed |=> fault_q[FLT_CARD])
    else $error("card change not latched");

  a_power_bad_latch: assert property (
    pins_valid && !pin_sync.power_good_feedback
    |=> fault_q[FLT_POWER_BAD])
    else $error("power bad not latched");

  a_overcurrent_latch: assert property (
    overcurrent_i |=> fault_q[FLT_OVERCURRENT])
    else $error("overcurrent not latched");

  a_under_latch: assert property (
    pins_valid && !pin_sync.undervoltage_input |=> fault_q[FLT_UNDER])
    else $error("undervoltage not latched");

  a_over_latch: assert property (
    pins_valid && pin_sync.supply_high_input |=> fault_q[FLT_OVER])
    else $error("overvoltage not latched");

  a_shunt_update: assert property (
    adc_i.valid && adc_i.channel == CH_SHUNT
    |=> st_reg.shunt_drop_result == $past(adc_i.data))
    else $error("shunt result not updated whole");

  a_rail_update: assert property (
    adc_i.valid && adc_i.channel == CH_RAIL
    ##1 reg_addr_i == ADDR_RAIL
    |=> reg_rdata_o == $past(adc_i.data, 2))
    else $error("rail result read back wrong");

  a_aux_update: assert property (
    adc_i.valid && adc_i.channel == CH_AUX
    |=> st_reg.aux_analog_result == $past(adc_i.data))
    else $error("aux result not updated whole");

  a_alert_pin: assert property (
    st_reg.alert |-> !general_pin_two_oe_n_o)
    else $error("alert pending but pin two released");

  a_alert_release: assert property (
    alert_release && !alert_req
    |=> !st_reg.alert
        && general_pin_two_oe_n_o == !fault_q[FLT_PIN_TWO])
    else $error("alert not released after response");

  a_no_realert: assert property (
    !st_reg.alert && !alert_req |=> !st_reg.alert)
    else $error("alert rose without a new enabled fault");

  a_clear_write: assert property (
    fault_wr && !reg_wdata_i[FLT_OVERCURRENT]
    && !fault_set[FLT_OVERCURRENT]
    |=> !fault_q[FLT_OVERCURRENT])
    else $error("host write did not clear fault bit");

  a_set_wins: assert property (
    fault_wr && fault_set[FLT_OVERCURRENT]
    |=> fault_q[FLT_OVERCURRENT])
    else $error("clearing write beat a new fault");

  c_alert_raised: cover property (
    $rose(alert_pending_o));

  c_alert_answered: cover property (
    alert_pending_o && ara_sent_i ##1 !alert_pending_o);

  c_fault_cleared: cover property (
    fault_q[FLT_CARD] && fault_wr ##1 !fault_q[FLT_CARD]);

  c_short_seen: cover property (
    $rose(fault_q[FLT_SHORT]));

endmodule // power_switch_monitor_regs

// *** testbench/host_port_model.sv ***
`timescale 1ns/1ns
module host_port_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [2:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  // Alert response
  output logic ara_sent_o,
  output logic addressed_o
);
  initial begin
    reg_addr_o = 3'h0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    ara_sent_o = 1'b0;
    addressed_o = 1'b0;
  end

  // Called just after a rising edge; returns just after the next one
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_o = a;
    reg_wr_o = 1'b1;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask

  task automatic point(input logic [2:0] a);
    reg_addr_o = a;
  endtask

  // Own address sent after alert response, or direct addressing
  task automatic release_alert(input logic direct, input int lag);
    repeat (lag) begin
      @(posedge clk_i);
      #1;
    end
    if (direct) begin
      addressed_o = 1'b1;
    end else begin
      ara_sent_o = 1'b1;
    end
    @(posedge clk_i);
    #1;
    addressed_o = 1'b0;
    ara_sent_o = 1'b0;
  endtask
endmodule // host_port_model

// *** testbench/power_switch_monitor_regs_tb.sv ***
`timescale 1ns/1ns
module power_switch_monitor_regs_tb
  import power_switch_monitor_pkg::*;
;
  localparam logic [8:0] IDLE = 9'h01c;
  logic clk_i, rst_i, overcurrent_i, chk, ara, hit, wr, alert;
  logic p2_o, p2_oe_n, p3_o, p3_oe_n;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, got;
  logic [8:0] pv, e;
  logic [31:0] seed;
  logic [7:0] res [3];
  adc_sample_t adc;
  pin_in_t pins_w;
  logic [8:0] expq [$];
  int mismatches, total_checks;

  // Open-drain pins with pull-ups: level follows the enable
  assign pins_w = {pv[8:7], p2_oe_n, p3_oe_n, pv[4:0]};

  power_switch_monitor_regs power_switch_monitor_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_w),
    .overcurrent_i(overcurrent_i), .adc_i(adc),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .ara_sent_i(ara), .addressed_i(hit),
    .general_pin_two_o(p2_o), .general_pin_two_oe_n_o(p2_oe_n),
    .general_pin_three_o(p3_o), .general_pin_three_oe_n_o(p3_oe_n),
    .alert_pending_o(alert));

  host_port_model host_port_model_i (
    .clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .ara_sent_o(ara), .addressed_o(hit));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  function automatic logic [7:0] stat(input logic [8:0] v);
    return {v[8], v[7], 1'b1, ~v[4], ~v[3], 1'b0, ~v[2], v[1] | v[0]};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic note(input logic k, input logic [7:0] v);
    expq.push_back({k, v});
    chk = 1'b1;
    step(1);
    chk = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] v);
    host_port_model_i.point(a);
    step(1);
    note(1'b0, v);
  endtask

  // Expected {alert, pin two enable_n, pin three enable_n}
  task automatic alert_is(input logic [2:0] v);
    note(1'b1, {5'h00, v});
  endtask

  task automatic cause(input int b);
    case (b)
      0: pv[1] = 1'b1;
      1: pv[2] = 1'b0;
      2: overcurrent_i = 1'b1;
      default: pv[3] = 1'b0;
    endcase
    step(4);
    pv = IDLE;
    overcurrent_i = 1'b0;
    step(4);
  endtask

  task automatic adc_put(input adc_channel_t c, input logic [7:0] d);
    adc = '{1'b1, c, d};
    step(1);
    adc = '{1'b0, CH_AUX, ~d};
  endtask

  always @(negedge clk_i) begin
    if (chk) begin
      e = expq.pop_front();
      got = e[8] ? {3'h0, p2_o, p3_o, alert, p2_oe_n, p3_oe_n} : rdata;
      total_checks++;
      if (got !== e[7:0]) begin
        mismatches++;
        $display("mismatch at %0t expected %h got %h", $time, e[7:0], got);
      end
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    results();
  end

  initial begin
    rst_i = 1'b1;
    pv = IDLE;
    overcurrent_i = 1'b0;
    adc = '0;
    chk = 1'b0;
    seed = 32'h3cf8;
    res = '{8'h00, 8'h00, 8'h00};
    mismatches = 0;
    total_checks = 0;
    step(4);
    rst_i = 1'b0;
    step(3);
    rd(ADDR_ALERT_MASK, 8'h00);
    rd(ADDR_FAULT, FAULT_RST);
    for (int a = 4; a < 8; a++) rd(3'(a), 8'h00);
    rd(3'h0, 8'h00);
    alert_is(3'b010);
    host_port_model_i.wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h20);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pv = seed[8:0];
      step(3);
      rd(ADDR_STATUS, stat(pv));
    end
    pv = IDLE;
    step(5);
    host_port_model_i.wr(ADDR_FAULT, 8'h80);
    rd(ADDR_FAULT, 8'h80);
    host_port_model_i.wr(ADDR_ALERT_MASK, 8'hff);
    rd(ADDR_ALERT_MASK, 8'h0f);
    for (int b = 0; b < 4; b++) begin
      cause(b);
      alert_is(3'b100);
      rd(ADDR_FAULT, 8'h80 | (8'h01 << b));
      host_port_model_i.release_alert(b[0], b);
      alert_is(3'b010);
      cause(b);
      alert_is(3'b010);
      host_port_model_i.wr(ADDR_FAULT, 8'h80);
      cause(b);
      alert_is(3'b100);
      host_port_model_i.release_alert(1'b0, 0);
      host_port_model_i.wr(ADDR_FAULT, 8'h80);
      rd(ADDR_FAULT, 8'h80);
    end
    host_port_model_i.wr(ADDR_ALERT_MASK, 8'h00);
    cause(2);
    alert_is(3'b010);
    overcurrent_i = 1'b1;
    host_port_model_i.wr(ADDR_FAULT, 8'h00);
    overcurrent_i = 1'b0;
    rd(ADDR_FAULT, 8'h04);
    alert_is(3'b011);
    step(2);
    rd(ADDR_STATUS, 8'h24);
    host_port_model_i.wr(ADDR_FAULT, 8'hc0);
    alert_is(3'b000);
    step(2);
    rd(ADDR_STATUS, 8'h00);
    host_port_model_i.wr(ADDR_FAULT, 8'h80);
    pv[8] = 1'b1;
    step(3);
    adc_put(CH_SHUNT, 8'h07);
    step(2);
    rd(ADDR_FAULT, 8'h80);
    pv[8] = 1'b0;
    step(3);
    rd(ADDR_FAULT, 8'ha0);
    adc_put(CH_SHUNT, 8'h06);
    host_port_model_i.wr(ADDR_FAULT, 8'h80);
    rd(ADDR_FAULT, 8'h80);
    res[0] = 8'h06;
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      adc_put(adc_channel_t'(seed[9:8]), seed[7:0]);
      if (seed[9:8] != 2'b11) res[seed[9:8]] = seed[7:0];
      rd(ADDR_SHUNT, res[0]);
      rd(ADDR_RAIL, res[1]);
      rd(ADDR_AUX, res[2]);
    end
    host_port_model_i.wr(ADDR_AUX, 8'h5a);
    rd(ADDR_AUX, 8'h5a);
    adc = '{1'b1, CH_RAIL, 8'h3c};
    host_port_model_i.wr(ADDR_RAIL, 8'hc3);
    adc = '0;
    rd(ADDR_RAIL, 8'h3c);
    rst_i = 1'b1;
    step(2);
    rst_i = 1'b0;
    step(3);
    rd(ADDR_FAULT, FAULT_RST);
    rd(ADDR_ALERT_MASK, 8'h00);
    results();
  end
endmodule // power_switch_monitor_regs_tb
